// ==== rtl/iafs_pkg.sv ====
// Purpose: Shared constants and types for the ack/arbitration flags and SCL generator
// Assumes: Wishbone classic slave, 32-bit data, byte addresses
// Notes: All offsets are byte addresses of aligned words
package iafs_pkg;

    // Register byte offsets
    localparam logic [7:0] IAFS_OFF_STATUS = 8'h00;
    localparam logic [7:0] IAFS_OFF_ENABLE = 8'h04;
    localparam logic [7:0] IAFS_OFF_CLEAR = 8'h08;
    localparam logic [7:0] IAFS_OFF_MODE = 8'h0c;
    localparam logic [7:0] IAFS_OFF_SCL_LOW = 8'h10;
    localparam logic [7:0] IAFS_OFF_SCL_HIGH = 8'h14;
    localparam logic [7:0] IAFS_OFF_SOURCE = 8'h18;

    // Status, enable and clear layout
    localparam int IAFS_BIT_AL = 0;
    localparam int IAFS_BIT_NACK = 1;
    localparam int IAFS_BIT_BUSY = 4;

    // Mode control layout
    localparam int IAFS_BIT_RST_N = 5;
    localparam int IAFS_BIT_MST = 10;
    localparam int IAFS_BIT_STP = 11;
    localparam int IAFS_BIT_START = 13;

    // Interrupt source codes
    localparam logic [2:0] IAFS_SRC_NONE = 3'h0;
    localparam logic [2:0] IAFS_SRC_AL = 3'h1;
    localparam logic [2:0] IAFS_SRC_NACK = 3'h2;

    // Divider width and fixed extension of each SCL phase
    localparam int IAFS_DIV_W = 16;
    localparam logic [IAFS_DIV_W:0] IAFS_DIV_EXTRA = 17'h00006;
    localparam logic [IAFS_DIV_W-1:0] IAFS_DIV_RESET = 16'h0000;

    // Events from the transfer engine
    typedef struct packed {
        logic transmitting;
        logic general_call;
        logic ack_seen;
        logic nack_seen;
        logic arb_lost;
        logic bus_busy;
    } iafs_evt_t;

    // Mode bits driven to the transfer engine
    typedef struct packed {
        logic module_reset_n;
        logic master_select;
        logic stop_request;
    } iafs_mode_t;

    // SCL generator phases
    typedef enum logic [1:0] {PH_IDLE, PH_LOW, PH_HIGH} iafs_phase_t;

endpackage

// ==== rtl/iafs_sclgen.sv ====
// Purpose: Master SCL generator dividing the module clock
// Assumes: Dividers are stable while run_i is high
// Notes: High phase counts only while the line is seen high, except its first cycle
`timescale 1ns/10ps
module iafs_sclgen
    import iafs_pkg::*;
#(
    parameter int DIV_W = IAFS_DIV_W
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic run_i,
    input wire logic scl_i,
    input wire logic [DIV_W-1:0] low_div_i,
    input wire logic [DIV_W-1:0] high_div_i,
    // Pin drive
    output logic scl_low_o
);

    iafs_phase_t phase_r;
    iafs_phase_t phase_nxt;
    logic [DIV_W:0] cnt_r;
    logic [DIV_W:0] cnt_nxt;
    logic [DIV_W:0] lim_lo;
    logic [DIV_W:0] lim_hi;
    logic [DIV_W:0] low_len_r;

    // Last count of each phase: divider plus six, minus one
    assign lim_lo = {1'b0, low_div_i} + IAFS_DIV_EXTRA - 17'h00001; // R14
    assign lim_hi = {1'b0, high_div_i} + IAFS_DIV_EXTRA - 17'h00001; // R14

    // Phase sequencing
    always_comb
    begin
        phase_nxt = phase_r;
        cnt_nxt = cnt_r;
        unique case (phase_r)
            PH_IDLE:
            begin
                cnt_nxt = '0;
                if (run_i)
                    phase_nxt = PH_LOW;
            end
            PH_LOW:
            begin
                if (cnt_r == lim_lo) // R13
                begin
                    phase_nxt = PH_HIGH;
                    cnt_nxt = '0;
                end
                else
                    cnt_nxt = cnt_r + 17'h00001;
            end
            PH_HIGH:
            begin
                // Another master holding SCL low stretches us
                if (scl_i && cnt_r == lim_hi) // R13
                begin
                    phase_nxt = PH_LOW;
                    cnt_nxt = '0;
                end
                // First cycle counts anyway: our release is still in the pin register
                else if (scl_i || cnt_r == '0)
                    cnt_nxt = cnt_r + 17'h00001;
            end
        endcase
        if (!run_i)
        begin
            phase_nxt = PH_IDLE;
            cnt_nxt = '0;
        end
    end

    // State and pin drive
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase_r <= PH_IDLE;
            cnt_r <= '0;
            scl_low_o <= 1'b0;
        end
        else
        begin
            phase_r <= phase_nxt;
            cnt_r <= cnt_nxt;
            scl_low_o <= (phase_nxt == PH_LOW);
        end
    end

    // Helper: length of the current low phase
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            low_len_r <= '0;
        else if (scl_low_o)
            low_len_r <= low_len_r + 17'h00001;
        else
            low_len_r <= '0;
    end

    chk_low_phase_len: assert property (@(posedge clk_i) disable iff (rst_i) // R14
        $fell(scl_low_o) && $past(run_i) |-> low_len_r == {1'b0, low_div_i} + IAFS_DIV_EXTRA)
        else $error("SCL low phase length wrong");

    chk_high_then_low: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        phase_r == PH_HIGH && scl_i && run_i && cnt_r == lim_hi |=> scl_low_o)
        else $error("SCL did not return low after high phase");

endmodule // iafs_sclgen

// ==== rtl/iafs_top.sv ====
// Purpose: I2C no-acknowledge and arbitration-lost flags with master SCL generator
// Assumes: Wishbone classic slave; event inputs synchronous to clk_i
// Notes: Transfer sequencing lives outside; this block keeps flags and modes
// How it works
// R1 - NACK flag sets when a transmitter sees a not-acknowledge.
// R2 - NACK flag clears when the receiver acknowledges a byte.
// R3 - Writing one to the NACK position clears it; zero leaves it.
// R4 - Reading the source code while it shows NACK clears the NACK flag.
// R5 - Both flags clear on module reset bit zero or chip reset.
// R6 - During a general call NACK reads one even if slaves acknowledge.
// R7 - Each flag can be polled and can raise its own interrupt.
// R8 - Master-transmitter losing arbitration sets the arbitration-lost flag.
// R9 - Starting a transfer while bus busy sets the arbitration-lost flag.
// R10 - Arbitration loss clears master select and stop request; becomes slave-receiver.
// R11 - Writing one to the arbitration-lost position clears it; zero does nothing.
// R12 - Reading the source code while it shows arbitration-lost clears that flag.
// R13 - In master mode SCL period is (low+6)+(high+6) module clocks.
// R14 - Low phase lasts low divider plus 6; high lasts high divider plus 6.
// R15 - Software sets dividers only while the module reset bit is zero.
// R16 - Flags stay set until cleared; a same-cycle set beats a clear.
`timescale 1ns/10ps
module iafs_top
    import iafs_pkg::*;
#(
    parameter int DIV_W = IAFS_DIV_W
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Transfer engine side
    input wire iafs_evt_t evt_i,
    output iafs_mode_t mode_o,
    output logic start_o,
    // Interrupt
    output logic irq_o,
    // Open-drain SCL pin
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Byte-lane merge used by the mode and divider registers
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                res[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return res;
    endfunction

    logic wb_ack_r;
    logic req;
    logic wr;
    logic rd;
    logic al_r;
    logic nack_r;
    logic [1:0] irq_en_r;
    logic [31:0] mode_r;
    logic [31:0] mode_nxt;
    logic [DIV_W-1:0] scl_low_div_r;
    logic [DIV_W-1:0] scl_high_div_r;
    logic [2:0] src_code;
    logic w1c_al;
    logic w1c_nack;
    logic set_al;
    logic set_nack;
    logic clr_al;
    logic clr_nack;
    logic start_req;
    logic mrn;
    logic scl_low;
    logic [31:0] rd_data;

    // Bus request decode: one new access per ack handshake
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_r;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;
    assign mrn = mode_r[IAFS_BIT_RST_N];

    ////////////////////////////////////////////////////////////////////////////////
    // Flag events

    // Arbitration loss outranks NACK in the source code
    assign src_code = al_r ? IAFS_SRC_AL : (nack_r ? IAFS_SRC_NACK : IAFS_SRC_NONE);

    // Write-one-to-clear through status or clear register, low lane only
    assign w1c_al = wr && wb_sel_i[0] && wb_dat_i[IAFS_BIT_AL]
        && (wb_adr_i == IAFS_OFF_STATUS || wb_adr_i == IAFS_OFF_CLEAR); // R11
    assign w1c_nack = wr && wb_sel_i[0] && wb_dat_i[IAFS_BIT_NACK]
        && (wb_adr_i == IAFS_OFF_STATUS || wb_adr_i == IAFS_OFF_CLEAR); // R3

    // Start attempt written through the mode register
    assign start_req = wr && wb_adr_i == IAFS_OFF_MODE && wb_sel_i[1]
        && wb_dat_i[IAFS_BIT_START] && mrn;

    // General call forces NACK even on an acknowledge
    assign set_nack = mrn && evt_i.transmitting
        && (evt_i.nack_seen || (evt_i.general_call && evt_i.ack_seen)); // R1 R6
    assign clr_nack = (evt_i.ack_seen && !evt_i.general_call) // R2
        || w1c_nack
        || (rd && wb_adr_i == IAFS_OFF_SOURCE && src_code == IAFS_SRC_NACK); // R4

    assign set_al = mrn && ((evt_i.arb_lost && mode_r[IAFS_BIT_MST] && evt_i.transmitting) // R8
        || (start_req && evt_i.bus_busy)); // R9
    assign clr_al = w1c_al
        || (rd && wb_adr_i == IAFS_OFF_SOURCE && src_code == IAFS_SRC_AL); // R12

    // NACK flag: reset first, then set over clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !mrn)
            nack_r <= 1'b0; // R5
        else if (set_nack)
            nack_r <= 1'b1; // R16
        else if (clr_nack)
            nack_r <= 1'b0;
    end

    // Arbitration-lost flag: reset first, then set over clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !mrn)
            al_r <= 1'b0; // R5
        else if (set_al)
            al_r <= 1'b1; // R16
        else if (clr_al)
            al_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers

    // Mode bits; arbitration loss drops master and stop even over a write
    always_comb
    begin
        mode_nxt = mode_r;
        if (wr && wb_adr_i == IAFS_OFF_MODE)
            mode_nxt = lane_merge(mode_r, wb_dat_i, wb_sel_i);
        mode_nxt[IAFS_BIT_START] = 1'b0;
        if (set_al)
        begin
            mode_nxt[IAFS_BIT_MST] = 1'b0; // R10
            mode_nxt[IAFS_BIT_STP] = 1'b0; // R10
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mode_r <= '0;
        else
            mode_r <= mode_nxt;
    end

    // Interrupt enables
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_en_r <= '0;
        else if (wr && wb_adr_i == IAFS_OFF_ENABLE && wb_sel_i[0])
            irq_en_r <= {wb_dat_i[IAFS_BIT_NACK], wb_dat_i[IAFS_BIT_AL]};
    end

    // Dividers; only meaningful when set while the module is held in reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scl_low_div_r <= IAFS_DIV_RESET;
            scl_high_div_r <= IAFS_DIV_RESET;
        end
        else
        begin
            if (wr && wb_adr_i == IAFS_OFF_SCL_LOW)
                scl_low_div_r <= DIV_W'(lane_merge(32'(scl_low_div_r), wb_dat_i, wb_sel_i));
            if (wr && wb_adr_i == IAFS_OFF_SCL_HIGH)
                scl_high_div_r <= DIV_W'(lane_merge(32'(scl_high_div_r), wb_dat_i, wb_sel_i));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone read mux and acknowledge

    always_comb
    begin
        rd_data = '0;
        unique case (wb_adr_i)
            IAFS_OFF_STATUS:
            begin
                rd_data[IAFS_BIT_AL] = al_r;
                rd_data[IAFS_BIT_NACK] = nack_r;
                rd_data[IAFS_BIT_BUSY] = evt_i.bus_busy;
            end
            IAFS_OFF_ENABLE:
            begin
                rd_data[IAFS_BIT_AL] = irq_en_r[0];
                rd_data[IAFS_BIT_NACK] = irq_en_r[1];
            end
            IAFS_OFF_MODE: rd_data = mode_r;
            IAFS_OFF_SCL_LOW: rd_data = 32'(scl_low_div_r);
            IAFS_OFF_SCL_HIGH: rd_data = 32'(scl_high_div_r);
            IAFS_OFF_SOURCE: rd_data = 32'(src_code);
            default: rd_data = '0; // Clear register and holes read zero
        endcase
    end

    // Single-cycle answer, dropped the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_r <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_r <= req;
            if (rd)
                wb_dat_o <= rd_data;
        end
    end
    assign wb_ack_o = wb_ack_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs to the transfer engine and interrupt

    // Start only passes when the bus is free
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            start_o <= 1'b0;
            mode_o <= '0;
            irq_o <= 1'b0;
        end
        else
        begin
            start_o <= start_req && !evt_i.bus_busy;
            mode_o.module_reset_n <= mode_nxt[IAFS_BIT_RST_N];
            mode_o.master_select <= mode_nxt[IAFS_BIT_MST];
            mode_o.stop_request <= mode_nxt[IAFS_BIT_STP];
            irq_o <= |({nack_r, al_r} & irq_en_r); // R7
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // SCL generation; open drain, so the pin is only ever pulled low

    iafs_sclgen #(
        .DIV_W(DIV_W)
    ) u_sclgen (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(mrn && mode_r[IAFS_BIT_MST]), // R13
        .scl_i(scl_i),
        .low_div_i(scl_low_div_r),
        .high_div_i(scl_high_div_r),
        .scl_low_o(scl_low)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scl_o <= 1'b0;
            scl_oe_n_o <= 1'b1;
        end
        else
        begin
            scl_o <= 1'b0;
            scl_oe_n_o <= !scl_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    chk_nack_set: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        mrn && evt_i.transmitting && evt_i.nack_seen |=> nack_r)
        else $error("NACK not set on not-acknowledge");

    chk_nack_ack_clr: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        evt_i.ack_seen && !evt_i.general_call && !set_nack |=> !nack_r)
        else $error("NACK not cleared on acknowledge");

    chk_nack_w1c: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        wr && wb_adr_i == IAFS_OFF_STATUS && wb_sel_i[0] && !wb_dat_i[IAFS_BIT_NACK]
        && nack_r && mrn && !clr_nack |=> nack_r)
        else $error("Writing zero changed NACK");

    chk_nack_src_rd: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        rd && wb_adr_i == IAFS_OFF_SOURCE && !al_r && nack_r && !set_nack
        |=> !nack_r && wb_dat_o == 32'(IAFS_SRC_NACK))
        else $error("Source read did not clear NACK");

    chk_flags_reset: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        !mrn |=> !nack_r && !al_r)
        else $error("Flags survived module reset");

    chk_gc_nack: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        mrn && evt_i.transmitting && evt_i.general_call && evt_i.ack_seen |=> nack_r)
        else $error("General call acknowledge cleared NACK");

    chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        ##1 irq_o == |({$past(nack_r), $past(al_r)} & $past(irq_en_r)))
        else $error("Interrupt output does not follow enabled flags");

    chk_al_set: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        mrn && evt_i.arb_lost && mode_r[IAFS_BIT_MST] && evt_i.transmitting |=> al_r)
        else $error("Arbitration loss not flagged");

    chk_busy_start: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        start_req && evt_i.bus_busy |=> al_r && !start_o)
        else $error("Start while busy not flagged");

    chk_al_mode: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        set_al |=> !mode_r[IAFS_BIT_MST] && !mode_r[IAFS_BIT_STP]
        ##1 !mode_o.master_select && !mode_o.stop_request)
        else $error("Arbitration loss left master mode on");

    chk_al_w1c: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        w1c_al && !set_al && mrn |=> !al_r)
        else $error("Write one did not clear arbitration loss");

    chk_al_src_rd: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        rd && wb_adr_i == IAFS_OFF_SOURCE && al_r && !set_al |=> !al_r)
        else $error("Source read did not clear arbitration loss");

    chk_set_wins: assert property (@(posedge clk_i) disable iff (rst_i) // R16
        set_nack && clr_nack |=> nack_r [*1] ##0 $stable(mrn) or !mrn)
        else $error("Clear beat a same-cycle NACK set");

endmodule // iafs_top

// ==== test/iafs_bus_model.sv ====
// Purpose: Far side of the SCL wire: pull-up plus a device that may stretch the clock
// Assumes: Master pulls the line low while its output enable is low
// Notes: Stretch length is sampled at each release by the master
`timescale 1ns/10ps
module iafs_bus_model
(
    // Clock
    input wire logic clk_i,
    // Line
    input wire logic scl_oe_n_i,
    input wire logic [3:0] stretch_i,
    output logic scl_o
);
    logic oe_n_d_r = 1'b1;
    logic [3:0] hold_r = 4'h0;
    logic rel;

    // Release seen this cycle; a slow device grabs the line at once
    assign rel = scl_oe_n_i && !oe_n_d_r;

    // Stretch counter, loaded on each release
    always_ff @(posedge clk_i)
    begin
        oe_n_d_r <= scl_oe_n_i;
        if (rel)
            hold_r <= stretch_i;
        else if (hold_r != 4'h0)
            hold_r <= hold_r - 4'h1;
    end

    // Wired-and with pull-up: high only when nobody pulls
    assign scl_o = scl_oe_n_i && (hold_r == 4'h0) && !(rel && stretch_i != 4'h0);
endmodule // iafs_bus_model

// ==== test/tb_i2c_ack_arb_flags_sclgen.sv ====
// Purpose: Self-checking bench for the flags, interrupt and SCL generator
// Assumes: Wishbone classic master; events driven at rising edges
// Notes: Flag model kept in integers; SCL phases measured into queues
`timescale 1ns/10ps
module tb_i2c_ack_arb_flags_sclgen;
    import iafs_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, ack, irq, start, oe_n, scl_ln, scl_pin;
    logic [7:0] adr;
    logic [3:0] sel, stretch;
    logic [31:0] dat, rdat, q, seed;
    iafs_evt_t evt;
    iafs_mode_t mode;
    int n_errors, n_compared, al_m, nk_m, bz_m, rn_m, ms_m, en_m, n_start, lo_c, hi_c, lo, hi;
    int lo_q[$];
    int hi_q[$];
    logic oe_d;

    iafs_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .evt_i(evt), .mode_o(mode), .start_o(start), .irq_o(irq), .scl_i(scl_ln),
        .scl_o(scl_pin), .scl_oe_n_o(oe_n));
    iafs_bus_model PEER (.clk_i(clk_i), .scl_oe_n_i(oe_n), .stretch_i(stretch), .scl_o(scl_ln));

    ////////////////////////////////////////////////////////////////////////////
    // Clock
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Start pulses and SCL phase lengths, sampled before each edge settles
    always @(posedge clk_i)
    begin
        if (start === 1'b1)
            n_start++;
        if (oe_n !== oe_d)
        begin
            if (oe_n)
                lo_q.push_back(lo_c);
            else
                hi_q.push_back(hi_c);
            lo_c = 0;
            hi_c = 0;
        end
        if (!oe_n)
            lo_c++;
        else
            hi_c++;
        oe_d = oe_n;
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    function automatic logic [31:0] st();
        return 32'(bz_m * 16 + nk_m * 2 + al_m);
    endfunction

    task automatic end_of_test();
        if (n_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %0t value %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %0t bit %b expected %b", $time, g, e);
        end
    endtask

    // One classic cycle; released at the edge where ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk32(q, e);
    endtask

    // Event pulse, model update, then interrupt level check
    task automatic ev(input logic [5:0] b);
        iafs_evt_t e;
        e = iafs_evt_t'({b[5:1], bz_m[0]});
        @(posedge clk_i);
        evt <= e;
        @(posedge clk_i);
        evt <= iafs_evt_t'({b[5:4], 3'h0, bz_m[0]});
        if (rn_m == 1)
        begin
            if (e.arb_lost && ms_m == 1)
            begin
                al_m = 1;
                ms_m = 0;
            end
            if (e.nack_seen || (e.general_call && e.ack_seen))
                nk_m = 1;
            else if (e.ack_seen)
                nk_m = 0;
        end
        // Interrupt follows the flag one edge later
        repeat (2) @(negedge clk_i);
        chk1(irq, (en_m & st()) != 0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {cyc, stb, we, adr, sel, dat, stretch, seed} = {3'h0, 8'h0, 4'hf, 32'h0, 4'h0, 32'h56d8};
        evt = '0;
        rst_i = 1'b1;
        oe_d = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++)
            rd(8'(i * 4), 32'h0);
        wb(1'b1, IAFS_OFF_MODE, 32'h20);
        rn_m = 1;
        wb(1'b1, IAFS_OFF_ENABLE, 32'h3);
        en_m = 3;
        ev(6'h24);
        rd(IAFS_OFF_STATUS, st());
        rd(IAFS_OFF_SOURCE, 32'h2);
        nk_m = 0;
        rd(IAFS_OFF_STATUS, st());
        ev(6'h24);
        ev(6'h28);
        rd(IAFS_OFF_STATUS, st());
        // Acknowledge and not-acknowledge together: the set wins
        ev(6'h2c);
        wb(1'b1, IAFS_OFF_CLEAR, 32'h0);
        rd(IAFS_OFF_STATUS, st());
        wb(1'b1, IAFS_OFF_CLEAR, 32'h2);
        nk_m = 0;
        rd(IAFS_OFF_STATUS, st());
        ev(6'h38);
        rd(IAFS_OFF_STATUS, st());
        wb(1'b1, IAFS_OFF_ENABLE, 32'h1);
        en_m = 1;
        @(negedge clk_i);
        chk1(irq, 1'b0);
        wb(1'b1, IAFS_OFF_ENABLE, 32'h3);
        en_m = 3;
        wb(1'b1, IAFS_OFF_STATUS, 32'h2);
        nk_m = 0;
        // Arbitration loss drops master and stop request
        wb(1'b1, IAFS_OFF_MODE, 32'hc20);
        ms_m = 1;
        ev(6'h26);
        rd(IAFS_OFF_MODE, 32'h20);
        chk32(32'(mode), 32'h4);
        rd(IAFS_OFF_SOURCE, 32'h1);
        al_m = 0;
        rd(IAFS_OFF_SOURCE, 32'h2);
        nk_m = 0;
        rd(IAFS_OFF_STATUS, st());
        // Start while busy is refused and flagged
        bz_m = 1;
        @(posedge clk_i);
        evt.bus_busy <= 1'b1;
        wb(1'b1, IAFS_OFF_MODE, 32'h2020);
        al_m = 1;
        @(negedge clk_i);
        chk32(32'(n_start), 32'h0);
        wb(1'b1, IAFS_OFF_STATUS, 32'h0);
        rd(IAFS_OFF_STATUS, st());
        wb(1'b1, IAFS_OFF_STATUS, 32'h1);
        al_m = 0;
        rd(IAFS_OFF_STATUS, st());
        bz_m = 0;
        @(posedge clk_i);
        evt.bus_busy <= 1'b0;
        wb(1'b1, IAFS_OFF_MODE, 32'h2020);
        @(negedge clk_i);
        chk32(32'(n_start), 32'h1);
        // Module reset clears both flags and masks events
        wb(1'b1, IAFS_OFF_MODE, 32'h420);
        ms_m = 1;
        ev(6'h26);
        wb(1'b1, IAFS_OFF_MODE, 32'h0);
        {rn_m, al_m, nk_m, ms_m} = 0;
        rd(IAFS_OFF_STATUS, st());
        ev(6'h24);
        rd(IAFS_OFF_STATUS, st());
        // Random dividers, written while held in module reset
        for (int k = 0; k < 4; k++)
        begin
            seed = xs(seed);
            lo = int'(seed[3:0]);
            hi = int'(seed[7:4]);
            stretch <= (k == 3) ? seed[11:8] : 4'h0;
            wb(1'b1, IAFS_OFF_SCL_LOW, 32'(lo));
            wb(1'b1, IAFS_OFF_SCL_HIGH, 32'(hi));
            rd(IAFS_OFF_SCL_HIGH, 32'(hi));
            lo_q.delete();
            hi_q.delete();
            wb(1'b1, IAFS_OFF_MODE, 32'h420);
            for (int n = 0; n < 900 && lo_q.size() < 3; n++)
                @(posedge clk_i);
            chk1(scl_pin, 1'b0);
            chk32(32'(lo_q[1]), 32'(lo + 6));
            if (k < 3)
                chk32(32'(lo_q[1] + hi_q[1]), 32'(lo + hi + 12));
            wb(1'b1, IAFS_OFF_MODE, 32'h0);
        end
        end_of_test();
    end

    // Watchdog well beyond the expected run
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        end_of_test();
    end
endmodule // tb_i2c_ack_arb_flags_sclgen
